// ### rtl/cdr_pkg.sv
/*
  Constants for the channel one diagnostic configuration and sense
  result register bank: offsets, field positions, reset values, timing.
  Assumes a register access port driven by the serial front end.
*/
// How it works
// - Bit 15 set disables voltage sensing
// - Bit 14 set disables temperature sensing
// - Bit 13 set disables current sensing
// - Threshold field is plain storage only
// - Bit 10 selects unity or eightfold gain
// - Bit 9 enables precise on-state open-load
// - Blanking code selects 0.4/1/2/4 ms
// - Bits 6-5 select pull-up current
// - Off open-load refused while on/faulted
// - Supply-short check refused while on/faulted
// - Bit 2 picks latch-off or auto-retry
// - Bits 1-0 select slew, reset two
// - Current result in bits 9-0
// - Temperature result in bits 9-0
// - Voltage result in bits 9-0
// - Bit 10 flags fresh result
package cdr_pkg;
  localparam logic [7:0]  OFS_DIAG_CFG  = 8'h10;
  localparam logic [7:0]  OFS_RES_CUR   = 8'h11;
  localparam logic [7:0]  OFS_RES_TEMP  = 8'h12;
  localparam logic [7:0]  OFS_RES_VOLT  = 8'h13;
  localparam logic [15:0] RST_DIAG_CFG  = 16'hc002;
  localparam logic [15:0] RST_RESULT    = 16'h0000;
  localparam int BIT_VSNS_DIS   = 15;
  localparam int BIT_TSNS_DIS   = 14;
  localparam int BIT_ISNS_DIS   = 13;
  localparam int POS_OL_THLD    = 11;
  localparam int BIT_GAIN       = 10;
  localparam int BIT_OL_ON_EN   = 9;
  localparam int POS_BLANK      = 7;
  localparam int POS_PU_STR     = 5;
  localparam int BIT_OL_OFF_EN  = 4;
  localparam int BIT_SUP_EN     = 3;
  localparam int BIT_LATCH      = 2;
  localparam int POS_SLEW       = 0;
  localparam int BIT_FRESH      = 10;
  localparam int RES_W          = 10;
  localparam int CLK_MHZ        = 50;
  localparam int BLANK0_US10    = 4;
  localparam int BLANK1_US10    = 10;
  localparam int BLANK2_US10    = 20;
  localparam int BLANK3_US10    = 40;
  // Tenths of ms to cycles: x * 100 us * CLK_MHZ
  localparam int BLANK0_CYC = BLANK0_US10 * 100 * CLK_MHZ;
  localparam int BLANK1_CYC = BLANK1_US10 * 100 * CLK_MHZ;
  localparam int BLANK2_CYC = BLANK2_US10 * 100 * CLK_MHZ;
  localparam int BLANK3_CYC = BLANK3_US10 * 100 * CLK_MHZ;
  localparam int PU_UA0         = 32;
  localparam int CNT_W          = 18;
endpackage

// ### rtl/cdr_result.sv
/*
  One sense result holder: 10-bit value plus fresh flag.
  Assumes conversion strobes and read strobes are clock synchronous.
*/
`timescale 1ns/1ps
module cdr_result
  import cdr_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_enable,
  input  wire logic             i_conv_vld,
  input  wire logic [RES_W-1:0] i_conv_data,
  input  wire logic             i_read,
  output logic      [15:0]      o_word
);
  logic [RES_W-1:0] value_ff;
  logic             fresh_ff;
  logic             take;

  assign take = i_conv_vld && i_enable;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      value_ff <= RST_RESULT[RES_W-1:0];
    end else if (take) begin
      value_ff <= i_conv_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fresh_ff <= 1'b0;
    end else if (take) begin
      fresh_ff <= 1'b1;
    end else if (i_read) begin
      fresh_ff <= 1'b0;
    end
  end

  assign o_word = {5'h00, fresh_ff, value_ff};

  // Fresh flag follows a stored conversion
  property p_fresh_set;
    @(posedge i_clk) disable iff (!i_rstn)
      take |=> fresh_ff && (value_ff == $past(i_conv_data));
  endproperty
  a_fresh_set: assert property (p_fresh_set)
    else $error("fresh flag not set after conversion");

  property p_fresh_clr;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_read && !take) |=> !fresh_ff;
  endproperty
  a_fresh_clr: assert property (p_fresh_clr)
    else $error("fresh flag not cleared by read");
endmodule

// ### rtl/cdr_regs.sv
/*
  Channel one diagnostic configuration and sense result register bank.
  Assumes a synchronous register port from the serial front end: one
  cycle write and read strobes; read data valid the cycle after.
*/
`timescale 1ns/1ps
module cdr_regs
  import cdr_pkg::*;
(
  input  wire logic             I_CLK,
  input  wire logic             I_RSTN,
  input  wire logic             I_WR,
  input  wire logic             I_RD,
  input  wire logic [7:0]       I_ADDR,
  input  wire logic [15:0]      I_WDATA,
  input  wire logic             I_CH_ON,
  input  wire logic             I_CH_FAULT,
  input  wire logic             I_LOAD_HIGH,
  input  wire logic             I_SWITCH_WR,
  input  wire logic             I_CUR_VLD,
  input  wire logic [RES_W-1:0] I_CUR_DATA,
  input  wire logic             I_TEMP_VLD,
  input  wire logic [RES_W-1:0] I_TEMP_DATA,
  input  wire logic             I_VOLT_VLD,
  input  wire logic [RES_W-1:0] I_VOLT_DATA,
  input  wire logic             I_LOAD_FAULT_RAW,
  output logic      [15:0]      O_RDATA,
  output logic                  O_RVALID,
  output logic                  O_VOLT_SENSE_EN,
  output logic                  O_TEMP_SENSE_EN,
  output logic                  O_CUR_SENSE_EN,
  output logic                  O_CURRENT_SENSE_GAIN,
  output logic                  O_ON_OPEN_LOAD_ENABLE,
  output logic      [1:0]       O_OFF_PULLUP_STRENGTH,
  output logic                  O_OFF_OPEN_LOAD_ENABLE,
  output logic                  O_SUPPLY_SHORT_CHECK_ENABLE,
  output logic                  O_FAULT_LATCH_SELECT,
  output logic      [1:0]       O_OUTPUT_SLEW_SELECT,
  output logic                  O_LOAD_FAULT,
  output logic                  O_LATCHED_OFF
);
  logic [15:0]      cfg_ff;
  logic [15:0]      nxt_cfg;
  logic [CNT_W-1:0] blank_cnt_ff;
  logic [CNT_W-1:0] blank_lim;
  logic [15:0]      cur_word;
  logic [15:0]      temp_word;
  logic [15:0]      volt_word;
  logic             wr_cfg;
  logic             rd_cur;
  logic             rd_temp;
  logic             rd_volt;
  logic             off_idle;
  logic [CNT_W-1:0] raw_run_ff;

  assign wr_cfg   = I_WR && (I_ADDR == OFS_DIAG_CFG);
  assign rd_cur   = I_RD && (I_ADDR == OFS_RES_CUR);
  assign rd_temp  = I_RD && (I_ADDR == OFS_RES_TEMP);
  assign rd_volt  = I_RD && (I_ADDR == OFS_RES_VOLT);
  assign off_idle = !I_CH_ON && !I_CH_FAULT;

  // Write filter on off-state checks and precise on-state open-load
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_cfg) begin
      nxt_cfg = I_WDATA;
      if (!off_idle) begin
        nxt_cfg[BIT_OL_OFF_EN] = 1'b0;
      end
      if (!off_idle) begin
        nxt_cfg[BIT_SUP_EN] = 1'b0;
      end
      if (I_CH_FAULT || I_LOAD_HIGH) begin
        nxt_cfg[BIT_OL_ON_EN] = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg_ff <= RST_DIAG_CFG;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Config fields to the analog side
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_VOLT_SENSE_EN             <= !RST_DIAG_CFG[BIT_VSNS_DIS];
      O_TEMP_SENSE_EN             <= !RST_DIAG_CFG[BIT_TSNS_DIS];
      O_CUR_SENSE_EN              <= !RST_DIAG_CFG[BIT_ISNS_DIS];
      O_CURRENT_SENSE_GAIN        <= RST_DIAG_CFG[BIT_GAIN];
      O_ON_OPEN_LOAD_ENABLE       <= RST_DIAG_CFG[BIT_OL_ON_EN];
      O_OFF_PULLUP_STRENGTH       <= RST_DIAG_CFG[POS_PU_STR +: 2];
      O_OFF_OPEN_LOAD_ENABLE      <= RST_DIAG_CFG[BIT_OL_OFF_EN];
      O_SUPPLY_SHORT_CHECK_ENABLE <= RST_DIAG_CFG[BIT_SUP_EN];
      O_FAULT_LATCH_SELECT        <= RST_DIAG_CFG[BIT_LATCH];
      O_OUTPUT_SLEW_SELECT        <= RST_DIAG_CFG[POS_SLEW +: 2];
    end else begin
      O_VOLT_SENSE_EN             <= !cfg_ff[BIT_VSNS_DIS];
      O_TEMP_SENSE_EN             <= !cfg_ff[BIT_TSNS_DIS];
      O_CUR_SENSE_EN              <= !cfg_ff[BIT_ISNS_DIS];
      O_CURRENT_SENSE_GAIN        <= cfg_ff[BIT_GAIN];
      O_ON_OPEN_LOAD_ENABLE       <= cfg_ff[BIT_OL_ON_EN];
      O_OFF_PULLUP_STRENGTH       <= cfg_ff[POS_PU_STR +: 2];
      O_OFF_OPEN_LOAD_ENABLE      <= cfg_ff[BIT_OL_OFF_EN];
      O_SUPPLY_SHORT_CHECK_ENABLE <= cfg_ff[BIT_SUP_EN];
      O_FAULT_LATCH_SELECT        <= cfg_ff[BIT_LATCH];
      O_OUTPUT_SLEW_SELECT        <= cfg_ff[POS_SLEW +: 2];
    end
  end

  always_comb begin
    case (cfg_ff[POS_BLANK +: 2])
      2'h0:    blank_lim = CNT_W'(BLANK0_CYC);
      2'h1:    blank_lim = CNT_W'(BLANK1_CYC);
      2'h2:    blank_lim = CNT_W'(BLANK2_CYC);
      default: blank_lim = CNT_W'(BLANK3_CYC);
    endcase
  end

  // Raw condition must persist the whole blanking time
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      blank_cnt_ff <= '0;
      O_LOAD_FAULT <= 1'b0;
    end else if (!I_LOAD_FAULT_RAW) begin
      blank_cnt_ff <= '0;
      O_LOAD_FAULT <= 1'b0;
    end else if (blank_cnt_ff >= blank_lim - CNT_W'(1)) begin
      O_LOAD_FAULT <= 1'b1;
    end else begin
      blank_cnt_ff <= blank_cnt_ff + CNT_W'(1);
    end
  end

  // Checker only: consecutive raw-high edges, saturating
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      raw_run_ff <= '0;
    end else if (!I_LOAD_FAULT_RAW) begin
      raw_run_ff <= '0;
    end else if (raw_run_ff != '1) begin
      raw_run_ff <= raw_run_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_LATCHED_OFF <= 1'b0;
    end else if (I_CH_FAULT && cfg_ff[BIT_LATCH]) begin
      O_LATCHED_OFF <= 1'b1;
    end else if (I_SWITCH_WR) begin
      O_LATCHED_OFF <= 1'b0;
    end
  end

  cdr_result u_cur (
    .i_clk       (I_CLK),
    .i_rstn      (I_RSTN),
    .i_enable    (!cfg_ff[BIT_ISNS_DIS]),
    .i_conv_vld  (I_CUR_VLD),
    .i_conv_data (I_CUR_DATA),
    .i_read      (rd_cur),
    .o_word      (cur_word)
  );

  cdr_result u_temp (
    .i_clk       (I_CLK),
    .i_rstn      (I_RSTN),
    .i_enable    (!cfg_ff[BIT_TSNS_DIS]),
    .i_conv_vld  (I_TEMP_VLD),
    .i_conv_data (I_TEMP_DATA),
    .i_read      (rd_temp),
    .o_word      (temp_word)
  );

  cdr_result u_volt (
    .i_clk       (I_CLK),
    .i_rstn      (I_RSTN),
    .i_enable    (!cfg_ff[BIT_VSNS_DIS]),
    .i_conv_vld  (I_VOLT_VLD),
    .i_conv_data (I_VOLT_DATA),
    .i_read      (rd_volt),
    .o_word      (volt_word)
  );

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RDATA  <= 16'h0000;
      O_RVALID <= 1'b0;
    end else begin
      O_RVALID <= I_RD;
      if (I_RD) begin
        case (I_ADDR)
          OFS_DIAG_CFG: O_RDATA <= cfg_ff;
          OFS_RES_CUR:  O_RDATA <= cur_word;
          OFS_RES_TEMP: O_RDATA <= temp_word;
          OFS_RES_VOLT: O_RDATA <= volt_word;
          default:      O_RDATA <= 16'h0000;
        endcase
      end
    end
  end

  property p_off_refuse;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (wr_cfg && I_CH_ON) |=> !cfg_ff[BIT_OL_OFF_EN];
  endproperty
  a_off_refuse: assert property (p_off_refuse)
    else $error("off open-load enabled while channel on");

  property p_sup_refuse;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (wr_cfg && I_CH_FAULT) |=> !cfg_ff[BIT_SUP_EN];
  endproperty
  a_sup_refuse: assert property (p_sup_refuse)
    else $error("supply short check enabled under fault");

  property p_vsense;
    @(posedge I_CLK) disable iff (!I_RSTN)
      ##1 O_VOLT_SENSE_EN == !$past(cfg_ff[BIT_VSNS_DIS]);
  endproperty
  a_vsense: assert property (p_vsense)
    else $error("voltage sense enable mismatch");

  property p_slew;
    @(posedge I_CLK) disable iff (!I_RSTN)
      wr_cfg |=> ##1 O_OUTPUT_SLEW_SELECT == $past(I_WDATA[1:0], 2);
  endproperty
  a_slew: assert property (p_slew)
    else $error("slew code not applied two cycles after write");

  property p_cur_read;
    @(posedge I_CLK) disable iff (!I_RSTN)
      rd_cur |=> O_RVALID && O_RDATA[15:11] == 5'h00;
  endproperty
  a_cur_read: assert property (p_cur_read)
    else $error("current result upper bits not zero");

  property p_latch;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (I_CH_FAULT && cfg_ff[BIT_LATCH]) |=> O_LATCHED_OFF;
  endproperty
  a_latch: assert property (p_latch)
    else $error("channel not latched off after fault");

  property p_blank;
    @(posedge I_CLK) disable iff (!I_RSTN)
      $rose(O_LOAD_FAULT) |-> $past(I_LOAD_FAULT_RAW);
  endproperty
  a_blank: assert property (p_blank)
    else $error("load fault without raw condition");

  property p_off_refuse_flt;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (wr_cfg && I_CH_FAULT) |=> !cfg_ff[BIT_OL_OFF_EN];
  endproperty
  a_off_refuse_flt: assert property (p_off_refuse_flt)
    else $error("off open-load enabled under fault");

  property p_sup_refuse_on;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (wr_cfg && I_CH_ON) |=> !cfg_ff[BIT_SUP_EN];
  endproperty
  a_sup_refuse_on: assert property (p_sup_refuse_on)
    else $error("supply short check enabled while channel on");

  property p_precise_refuse;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (wr_cfg && (I_CH_FAULT || I_LOAD_HIGH)) |=> !cfg_ff[BIT_OL_ON_EN];
  endproperty
  a_precise_refuse: assert property (p_precise_refuse)
    else $error("precise open-load enabled under fault or high load");

  // Unfiltered fields land exactly as written
  property p_cfg_store;
    @(posedge I_CLK) disable iff (!I_RSTN)
      wr_cfg |=>
        cfg_ff[BIT_VSNS_DIS:BIT_GAIN] == $past(I_WDATA[BIT_VSNS_DIS:BIT_GAIN])
        && cfg_ff[BIT_OL_ON_EN-1:POS_PU_STR]
           == $past(I_WDATA[BIT_OL_ON_EN-1:POS_PU_STR])
        && cfg_ff[BIT_LATCH:POS_SLEW] == $past(I_WDATA[BIT_LATCH:POS_SLEW]);
  endproperty
  a_cfg_store: assert property (p_cfg_store)
    else $error("configuration field not stored as written");

  property p_tsense;
    @(posedge I_CLK) disable iff (!I_RSTN)
      wr_cfg |=> ##1 O_TEMP_SENSE_EN == !$past(I_WDATA[BIT_TSNS_DIS], 2);
  endproperty
  a_tsense: assert property (p_tsense)
    else $error("temperature sense enable not applied after write");

  property p_isense;
    @(posedge I_CLK) disable iff (!I_RSTN)
      wr_cfg |=> ##1 O_CUR_SENSE_EN == !$past(I_WDATA[BIT_ISNS_DIS], 2);
  endproperty
  a_isense: assert property (p_isense)
    else $error("current sense enable not applied after write");

  property p_gain;
    @(posedge I_CLK) disable iff (!I_RSTN)
      wr_cfg |=> ##1 O_CURRENT_SENSE_GAIN == $past(I_WDATA[BIT_GAIN], 2);
  endproperty
  a_gain: assert property (p_gain)
    else $error("current sense gain not applied after write");

  property p_pullup;
    @(posedge I_CLK) disable iff (!I_RSTN)
      wr_cfg |=> ##1
        O_OFF_PULLUP_STRENGTH == $past(I_WDATA[POS_PU_STR +: 2], 2);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up strength not applied after write");

  property p_res_read;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (rd_temp || rd_volt) |=> O_RVALID && O_RDATA[15:11] == 5'h00;
  endproperty
  a_res_read: assert property (p_res_read)
    else $error("temperature or voltage result upper bits not zero");

  // Fault never rises before the shortest blanking time
  property p_blank_min;
    @(posedge I_CLK) disable iff (!I_RSTN)
      $rose(O_LOAD_FAULT) |-> raw_run_ff >= CNT_W'(BLANK0_CYC);
  endproperty
  a_blank_min: assert property (p_blank_min)
    else $error("load fault raised before blanking time");

  property p_blank_drop;
    @(posedge I_CLK) disable iff (!I_RSTN)
      !I_LOAD_FAULT_RAW |=> !O_LOAD_FAULT;
  endproperty
  a_blank_drop: assert property (p_blank_drop)
    else $error("load fault held after raw condition ended");

  property p_latch_hold;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (O_LATCHED_OFF && !I_SWITCH_WR) |=> O_LATCHED_OFF;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched-off state lost without switch write");
endmodule

// ### tb/cdr_host.sv
/*
  Host side model of the register port: word writes and reads.
  Assumes the bench clock; strobes change at the falling edge only.
*/
`timescale 1ns/1ps
module cdr_host (
  input  wire logic        i_clk,
  input  wire logic        i_rvalid,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_addr,
  output logic [15:0]      o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // Released bus shows a changed value, never the old one
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rvalid ? i_rdata : 16'hxxxx;
  endtask
endmodule

// ### tb/testbench.sv
/*
  Self-checking bench for the diagnostic register bank.
  Assumes the host model in cdr_host drives the register port.
*/
`timescale 1ns/1ps
module testbench;
  import cdr_pkg::*;
  logic        clk, rstn, wr, rd, on, flt, lh, swr, raw, rvalid;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, m_cfg;
  logic [2:0]  vld;
  logic [9:0]  dat [3];
  logic [9:0]  m_val [3];
  logic        m_fr [3];
  logic        vse, tse, cse, gain, olon, oloff, sup, lat, lf, lo;
  logic [1:0]  pus, slew;
  int          fails, n_tests;
  cdr_host host_i (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  cdr_regs cdr_regs_i (.I_CLK(clk), .I_RSTN(rstn), .I_WR(wr), .I_RD(rd),
    .I_ADDR(addr), .I_WDATA(wdata), .I_CH_ON(on), .I_CH_FAULT(flt),
    .I_LOAD_HIGH(lh), .I_SWITCH_WR(swr), .I_CUR_VLD(vld[0]),
    .I_CUR_DATA(dat[0]), .I_TEMP_VLD(vld[1]), .I_TEMP_DATA(dat[1]),
    .I_VOLT_VLD(vld[2]), .I_VOLT_DATA(dat[2]), .I_LOAD_FAULT_RAW(raw),
    .O_RDATA(rdata), .O_RVALID(rvalid), .O_VOLT_SENSE_EN(vse),
    .O_TEMP_SENSE_EN(tse), .O_CUR_SENSE_EN(cse),
    .O_CURRENT_SENSE_GAIN(gain), .O_ON_OPEN_LOAD_ENABLE(olon),
    .O_OFF_PULLUP_STRENGTH(pus), .O_OFF_OPEN_LOAD_ENABLE(oloff),
    .O_SUPPLY_SHORT_CHECK_ENABLE(sup), .O_FAULT_LATCH_SELECT(lat),
    .O_OUTPUT_SLEW_SELECT(slew), .O_LOAD_FAULT(lf), .O_LATCHED_OFF(lo));
  task test_done;
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a);
    logic [15:0] e, g;
    int q;
    q = int'(a) - 17;
    e = 16'h0000;
    if (a == OFS_DIAG_CFG)
      e = m_cfg;
    else if (q >= 0 && q < 3) begin
      e = {5'h00, m_fr[q], m_val[q]};
      m_fr[q] = 1'b0;
    end
    host_i.rd(a, g);
    chk(g, e);
  endtask
  task automatic fchk;
    chk({4'h0, vse, tse, cse, gain, olon, pus, oloff, sup, lat, slew},
      {4'h0, ~m_cfg[15], ~m_cfg[14], ~m_cfg[13], m_cfg[10], m_cfg[9],
      m_cfg[6:5], m_cfg[4], m_cfg[3], m_cfg[2], m_cfg[1:0]});
  endtask
  task automatic w(input logic [15:0] d);
    host_i.wr(OFS_DIAG_CFG, d);
    if (on | flt)
      d[4:3] = 2'b00;
    if (flt | lh)
      d[9] = 1'b0;
    m_cfg = d;
    @(negedge clk);
  endtask
  task automatic cv(input int q);
    logic [9:0] d;
    d = 10'($urandom);
    @(negedge clk);
    vld[q] = 1'b1;
    dat[q] = d;
    @(negedge clk);
    vld[q] = 1'b0;
    dat[q] = ~d;
    if (!m_cfg[13+q]) begin
      m_val[q] = d;
      m_fr[q] = 1'b1;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    // Two blanking runs dominate: about 70k cycles
    #(90000 * 20);
    fails++;
    test_done;
  end
  initial begin
    {rstn, on, flt, lh, swr, raw, vld} = '0;
    dat = '{10'h000, 10'h000, 10'h000};
    m_val = '{10'h000, 10'h000, 10'h000};
    m_fr = '{1'b0, 1'b0, 1'b0};
    m_cfg = RST_DIAG_CFG;
    fails = 0;
    n_tests = 0;
    void'($urandom(32'h5753));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    fchk;
    for (int a = 16; a < 21; a++)
      rc(8'(a));
    for (int i = 0; i < 8; i++) begin
      // Host keeps the checks clear of on, fault and high load first
      {on, flt, lh} = (i < 4) ? 3'b000 : 3'b100 >> (i % 4);
      w(16'($urandom) | ((i < 4) ? 16'h0000 : 16'h0218));
      fchk;
      rc(OFS_DIAG_CFG);
    end
    {on, flt, lh} = 3'b000;
    w(16'h0000);
    for (int q = 0; q < 3; q++) begin
      cv(q);
      rc(8'(17 + q));
      rc(8'(17 + q));
      cv(q);
      host_i.wr(8'(17 + q), 16'hffff);
      rc(8'(17 + q));
    end
    w(16'he000);
    for (int q = 0; q < 3; q++) begin
      cv(q);
      rc(8'(17 + q));
    end
    for (int b = 0; b < 2; b++) begin
      // Latch mode, blanking code b; clear any latch left by the loop
      w(b ? 16'h0084 : 16'h0004);
      swr = 1'b1;
      @(negedge clk);
      swr = 1'b0;
      raw = 1'b1;
      repeat ((b ? BLANK1_CYC : BLANK0_CYC) - 5) @(negedge clk);
      chk({14'h0000, lf, lo}, 16'h0000);
      repeat (10) @(negedge clk);
      chk({14'h0000, lf, lo}, 16'h0002);
      flt = 1'b1;
      @(negedge clk);
      flt = 1'b0;
      raw = 1'b0;
      repeat (3) @(negedge clk);
      chk({14'h0000, lf, lo}, 16'h0001);
      swr = 1'b1;
      @(negedge clk);
      swr = 1'b0;
      @(negedge clk);
      chk({15'h0000, lo}, 16'h0000);
    end
    // Auto-retry mode: a fault must not latch
    w(16'h0000);
    flt = 1'b1;
    @(negedge clk);
    flt = 1'b0;
    @(negedge clk);
    chk({15'h0000, lo}, 16'h0000);
    test_done;
  end
endmodule
